// >>> core/fuc_pkg.sv
// Package for the FIFO UART core: register map, fields, reset values, timing counts and carrier types
package fuc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_IER = 3'h1;
    localparam logic [2:0] REG_IIR_FCR = 3'h2;
    localparam logic [2:0] REG_LCR = 3'h3;
    localparam logic [2:0] REG_MCR = 3'h4;
    localparam logic [2:0] REG_LSR = 3'h5;
    localparam logic [2:0] REG_MSR = 3'h6;
    localparam logic [2:0] REG_SCR = 3'h7;
    // Line control field positions
    localparam int LCR_DIVISOR_ACCESS_BIT = 7;
    localparam int LCR_BREAK = 6;
    localparam int LCR_STICK = 5;
    localparam int LCR_EVEN = 4;
    localparam int LCR_PEN = 3;
    localparam int LCR_STOP = 2;
    // FIFO control field positions
    localparam int FCR_EN = 0;
    localparam int FCR_RXCLR = 1;
    localparam int FCR_TXCLR = 2;
    localparam int FCR_DMA = 3;
    // Interrupt enable bits
    localparam int IER_RDA = 0;
    localparam int IER_TX_HOLDING_EMPTY_IRQ = 1;
    localparam int IER_RLS = 2;
    localparam int IER_MS = 3;
    // Interrupt identification codes
    localparam logic [3:0] IID_NONE = 4'h1;
    localparam logic [3:0] IID_RLS = 4'h6;
    localparam logic [3:0] IID_RDA = 4'h4;
    localparam logic [3:0] IID_CTO = 4'hc;
    localparam logic [3:0] IID_TX_HOLDING_EMPTY_IRQ = 4'h2;
    localparam logic [3:0] IID_MS = 4'h0;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_DIV = 16'h0000;
    // Receive status and transmit start delays in sampling-clock cycles
    localparam int RX_FIFO_DELAY = 3;
    localparam int RX_PLAIN_DELAY = 1;
    localparam int RX_TIMEOUT_DELAY = 8;
    localparam int TX_START_WAIT = 8;
    // Character-timeout window in character times
    localparam int CTO_CHARS = 4;
    localparam int OVERSAMPLE = 16;
    // Receive FIFO entry: data plus parity, framing and break status
    typedef struct packed {
        logic brk;
        logic fe;
        logic pe;
        logic [7:0] data;
    } fuc_rx_entry_s;
    // Modem input bundle (active high, already complemented)
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } fuc_modem_s;
endpackage

// >>> core/fuc_uart.sv
// FIFO UART core with APB register access, baud generator, transmitter, receiver and modem lines
// Behaviour
// - Sixteen-byte transmit and receive FIFOs in FIFO mode
// - Reset leaves FIFO mode disabled
// - Five to eight data bits
// - Even, odd or no parity
// - One or two stop bits, or half a stop bit for five bits
// - Sixteen-bit baud divisor
// - Non-FIFO data ready one sample after stop
// - FIFO-mode receive indications three samples late
// - FIFO status three samples late, then on read
// - Timeout interrupt eight samples after condition
// - Transmit start within 8-24 baud cycles
// - Transmit DMA request active within 8 cycles
// - Interrupt delay extends by character minus stop
// - Parity, overrun, framing, break reported in status
// - Holding write clears transmit-empty interrupt
// - Identification read clears reported transmit-empty interrupt
// - Data or status read clears its interrupt
// - Modem status read clears modem interrupt
// - Modem input change sets modem interrupt; ring indicator only on its trailing edge
// - Filling transmit path drops DMA request
// - Divisor access bit maps divisor bytes
// - Reset clears all but data and divisor, and sets the transmit-empty interrupt
// - Receiver samples at sixteen times baud
`timescale 1ns/100ps
module fuc_uart #(
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_in,
    output logic serial_out,
    input wire fuc_pkg::fuc_modem_s modem_in,
    output logic dtr_n,
    output logic rts_n,
    output logic out1_n,
    output logic out2_n,
    output logic baud_out_n,
    output logic interrupt_output,
    output logic tx_dma_request_n,
    output logic rx_dma_request_n
);
    import fuc_pkg::*;

    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} fuc_tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_DONE} fuc_rx_e;

    // All state of the core except the FIFO memories and prdata in one record
    typedef struct packed {
        logic [15:0] divisor;
        logic [15:0] bcnt;
        logic btick_q;
        logic [7:0] ier;
        logic [7:0] lcr;
        logic [7:0] modem_control_reg;
        logic [7:0] scr;
        logic [1:0] rx_trig;
        logic fifo_en;
        logic dma_mode;
        logic [7:0] tx_hold;
        logic tx_empty_irq;
        logic thr_full; // Holding byte waits; kept apart from the interrupt so a clearing read sends nothing
        logic [AW:0] tx_cnt;
        logic [AW-1:0] tx_rd;
        logic [AW-1:0] tx_wr;
        fuc_tx_e tx_st;
        logic [4:0] tx_wait;
        logic [3:0] tx_sub;
        logic [4:0] tx_bit;
        logic [11:0] tx_shift;
        logic tx_line;
        logic tx_dma_blk;
        fuc_rx_e rx_st;
        logic [3:0] rx_sub;
        logic [3:0] rx_bit;
        logic [10:0] rx_shift;
        logic [3:0] rx_delay;
        fuc_rx_entry_s rx_pend;
        logic [AW:0] rx_cnt;
        logic [AW-1:0] rx_rd;
        logic [AW-1:0] rx_wr;
        logic [7:0] rx_buffer_reg;
        logic data_ready;
        logic overrun;
        logic pe;
        logic fe;
        logic brk;
        logic [9:0] cto_cnt;
        logic [3:0] cto_dly;
        logic cto_irq;
        fuc_modem_s m_prev;
        logic [3:0] m_delta;
    } fuc_state_s;

    fuc_state_s st;
    fuc_state_s next_st;
    logic [7:0] tx_mem [DEPTH];
    fuc_rx_entry_s rx_mem [DEPTH];

    logic wr_acc;
    logic rd_acc;
    logic [2:0] idx;
    logic divisor_access_bit;
    logic tick16;
    logic [3:0] nbits;
    logic tx_push;
    logic tx_pop;
    logic rx_pop;
    logic rx_push;
    logic rx_avail;
    logic tx_has;
    logic [3:0] iid;
    logic [7:0] rd_byte;
    fuc_rx_entry_s rx_head;
    logic line_in;
    logic [4:0] trig_lvl;

    // APB: zero wait states, never an error; address bits above 4 are ignored, so higher words alias
    assign idx = paddr[4:2];
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign divisor_access_bit = st.lcr[LCR_DIVISOR_ACCESS_BIT];
    assign nbits = 4'd5 + {2'b00, st.lcr[1:0]};
    assign tick16 = st.btick_q;
    assign line_in = st.modem_control_reg[4] ? st.tx_line : serial_in;
    assign rx_head = rx_mem[st.rx_rd];
    assign tx_has = st.fifo_en ? (st.tx_cnt != '0) : st.thr_full;
    assign rx_avail = st.data_ready;
    assign tx_push = wr_acc && idx == REG_DATA && !divisor_access_bit && st.tx_cnt != (AW+1)'(DEPTH);
    assign rx_pop = rd_acc && idx == REG_DATA && !divisor_access_bit;
    always_comb begin
        unique case (st.rx_trig)
            2'd0: trig_lvl = 5'd1;
            2'd1: trig_lvl = 5'd4;
            2'd2: trig_lvl = 5'd8;
            default: trig_lvl = 5'd14;
        endcase
    end

    // Interrupt priority: line status, data, timeout, holding empty, modem
    always_comb begin
        iid = IID_NONE;
        if (st.ier[IER_RLS] && (st.overrun | st.pe | st.fe | st.brk)) begin
            iid = IID_RLS;
        end else if (st.ier[IER_RDA] && st.data_ready &&
                     (!st.fifo_en || 5'(st.rx_cnt) >= trig_lvl)) begin
            iid = IID_RDA;
        end else if (st.ier[IER_RDA] && st.cto_irq) begin
            iid = IID_CTO;
        end else if (st.ier[IER_TX_HOLDING_EMPTY_IRQ] && st.tx_empty_irq) begin
            iid = IID_TX_HOLDING_EMPTY_IRQ;
        end else if (st.ier[IER_MS] && st.m_delta != 4'h0) begin
            iid = IID_MS;
        end
    end
    assign interrupt_output = ~iid[0];

    // Read mux; holding-empty flag equals empty transmit path
    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            REG_DATA: rd_byte = divisor_access_bit ? st.divisor[7:0] : st.rx_buffer_reg;
            REG_IER: rd_byte = divisor_access_bit ? st.divisor[15:8] : {4'h0, st.ier[3:0]};
            REG_IIR_FCR: rd_byte = {{2{st.fifo_en}}, 2'b00, iid};
            REG_LCR: rd_byte = st.lcr;
            REG_MCR: rd_byte = {3'b000, st.modem_control_reg[4:0]};
            REG_LSR: rd_byte = {st.fifo_en & (st.pe | st.fe | st.brk),
                                ~tx_has & st.tx_st == TX_IDLE, ~tx_has,
                                st.brk, st.fe, st.pe, st.overrun, st.data_ready};
            REG_MSR: rd_byte = {(st.modem_control_reg[4] ? {st.modem_control_reg[3], st.modem_control_reg[2], st.modem_control_reg[0], st.modem_control_reg[1]} : modem_in),
                                st.m_delta};
            default: rd_byte = st.scr;
        endcase
    end

    // Next-state logic for the whole core
    always_comb begin
        logic [10:0] frame;
        logic par;
        logic rpar;
        fuc_rx_entry_s ent;
        next_st = st;
        frame = '0;
        par = 1'b0;
        rpar = 1'b0;
        ent = '0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        // Baud generator: one tick per divisor count of the sampling clock
        next_st.btick_q = 1'b0;
        if (st.divisor != RST_DIV) begin
            if (st.bcnt <= 16'h0001) begin
                next_st.bcnt = st.divisor;
                next_st.btick_q = 1'b1;
            end else begin
                next_st.bcnt = st.bcnt - 16'h0001;
            end
        end
        // Register writes
        if (wr_acc) begin
            unique case (idx)
                REG_DATA: if (divisor_access_bit) next_st.divisor[7:0] = pwdata[7:0];
                REG_IER: if (divisor_access_bit) next_st.divisor[15:8] = pwdata[7:0];
                         else next_st.ier = {4'h0, pwdata[3:0]};
                REG_IIR_FCR: begin
                    next_st.fifo_en = pwdata[FCR_EN];
                    next_st.dma_mode = pwdata[FCR_DMA];
                    next_st.rx_trig = pwdata[7:6];
                    if (pwdata[FCR_RXCLR] || pwdata[FCR_EN] != st.fifo_en) begin
                        next_st.rx_cnt = '0;
                        next_st.rx_rd = '0;
                        next_st.rx_wr = '0;
                        next_st.data_ready = 1'b0;
                    end
                    if (pwdata[FCR_TXCLR] || pwdata[FCR_EN] != st.fifo_en) begin
                        next_st.thr_full = 1'b0;
                        next_st.tx_cnt = '0;
                        next_st.tx_rd = '0;
                        next_st.tx_wr = '0;
                    end
                end
                REG_LCR: next_st.lcr = pwdata[7:0];
                REG_MCR: next_st.modem_control_reg = {3'b000, pwdata[4:0]};
                REG_SCR: next_st.scr = pwdata[7:0];
                default: ;
            endcase
        end
        // Holding register write clears the empty interrupt; blocks DMA unless in FIFO DMA mode with room left
        if (tx_push) begin
            next_st.tx_empty_irq = 1'b0;
            if (st.fifo_en) begin
                next_st.tx_wr = st.tx_wr + 1'b1;
                next_st.tx_cnt = st.tx_cnt + 1'b1;
                if (st.tx_cnt == (AW+1)'(DEPTH - 1) || !st.dma_mode) next_st.tx_dma_blk = 1'b1;
            end else begin
                next_st.tx_hold = pwdata[7:0];
                next_st.thr_full = 1'b1;
                next_st.tx_dma_blk = 1'b1;
            end
        end
        if (rd_acc && idx == REG_IIR_FCR && iid == IID_TX_HOLDING_EMPTY_IRQ) next_st.tx_empty_irq = 1'b0;
        // Transmitter: after data arrives, counts TX_START_WAIT sample ticks and starts on the next
        unique case (st.tx_st)
            TX_IDLE: if (tx_has) begin
                next_st.tx_st = TX_WAIT;
                next_st.tx_wait = 5'(TX_START_WAIT);
            end
            TX_WAIT: if (st.btick_q) begin
                if (st.tx_wait == 5'd0) begin
                    frame = st.fifo_en ? {3'b000, tx_mem[st.tx_rd]} : {3'b000, st.tx_hold};
                    frame = frame & ~(11'h7ff << nbits);
                    par = ^frame[7:0] ^ ~st.lcr[LCR_EVEN];
                    if (st.lcr[LCR_STICK]) par = ~st.lcr[LCR_EVEN];
                    // Frame built LSB first: start, data, parity, stops, idle ones above
                    next_st.tx_shift = {1'b1, 11'h7ff} & ~12'h001;
                    next_st.tx_shift[8:1] = frame[7:0];
                    if (st.lcr[LCR_PEN]) next_st.tx_shift[nbits+1] = par;
                    next_st.tx_bit = 5'(nbits) + 5'(st.lcr[LCR_PEN]) + 5'd1;
                    next_st.tx_sub = 4'd0;
                    next_st.tx_st = TX_SHIFT;
                    tx_pop = 1'b1;
                    next_st.tx_dma_blk = 1'b0;
                    if (!st.fifo_en && !tx_push) next_st.thr_full = 1'b0;
                    if (st.fifo_en) begin
                        next_st.tx_rd = st.tx_rd + 1'b1;
                        next_st.tx_cnt = st.tx_cnt - 1'b1;
                    end
                end else begin
                    next_st.tx_wait = st.tx_wait - 5'd1;
                end
            end
            default: if (st.btick_q) begin
                next_st.tx_sub = st.tx_sub + 4'd1;
                if (st.tx_sub == 4'd15) begin
                    next_st.tx_shift = {1'b1, st.tx_shift[11:1]};
                    next_st.tx_bit = st.tx_bit - 5'd1;
                end
                // Stop length: one, half a bit for five bits, else two
                if ((st.tx_bit == 5'd0 && !st.lcr[LCR_STOP] && st.tx_sub == 4'd15) ||
                    (st.tx_bit == 5'd0 && st.lcr[LCR_STOP] && nbits == 4'd5 && st.tx_sub == 4'd7) ||
                    (st.tx_bit == 5'h1f && st.tx_sub == 4'd15)) begin
                    next_st.tx_st = TX_IDLE;
                    next_st.tx_bit = 5'd0;
                    if ((!tx_has || st.tx_cnt == (AW+1)'(1)) && !tx_push) next_st.tx_empty_irq = 1'b1;
                end
            end
        endcase
        // A holding write in the same cycle keeps the path non-empty
        if (st.tx_st == TX_SHIFT && st.tx_bit == 5'd0 && !tx_has && !tx_push) next_st.tx_empty_irq = 1'b1;
        next_st.tx_line = st.tx_st == TX_SHIFT ? st.tx_shift[0] : 1'b1;
        // Receiver: 16x sampling, start validated mid-bit
        if (tick16) begin
            unique case (st.rx_st)
                RX_IDLE: if (!line_in) begin
                    next_st.rx_sub = st.rx_sub + 4'd1;
                    if (st.rx_sub == 4'd7) begin
                        next_st.rx_st = RX_SHIFT;
                        next_st.rx_sub = 4'd0;
                        next_st.rx_bit = 4'd0;
                    end
                end else next_st.rx_sub = 4'd0;
                RX_SHIFT: begin
                    next_st.rx_sub = st.rx_sub + 4'd1;
                    if (st.rx_sub == 4'd15) begin
                        next_st.rx_shift = {line_in, st.rx_shift[10:1]};
                        next_st.rx_bit = st.rx_bit + 4'd1;
                        if (st.rx_bit == nbits + 4'(st.lcr[LCR_PEN])) begin
                            next_st.rx_st = RX_DONE;
                            next_st.rx_delay = st.fifo_en ? 4'(RX_FIFO_DELAY) : 4'(RX_PLAIN_DELAY);
                        end
                    end
                end
                default: begin
                    ent.data = 8'(st.rx_shift >> (4'd10 - nbits - 4'(st.lcr[LCR_PEN]))) & ~(8'hff << nbits);
                    rpar = ^ent.data ^ ~st.lcr[LCR_EVEN];
                    if (st.lcr[LCR_STICK]) rpar = ~st.lcr[LCR_EVEN];
                    ent.pe = st.lcr[LCR_PEN] && st.rx_shift[9] != rpar;
                    ent.fe = !st.rx_shift[10];
                    ent.brk = st.rx_shift == '0;
                    next_st.rx_pend = ent;
                    next_st.rx_delay = st.rx_delay - 4'd1;
                    if (st.rx_delay == 4'd1) begin
                        rx_push = 1'b1;
                        next_st.rx_st = RX_IDLE;
                        next_st.rx_sub = 4'd0;
                    end
                end
            endcase
        end
        // Receive commit and host read
        if (rx_pop && st.fifo_en && st.rx_cnt != '0) begin
            next_st.rx_rd = st.rx_rd + 1'b1;
            next_st.rx_cnt = st.rx_cnt - 1'b1;
            next_st.data_ready = st.rx_cnt != 1;
            // Status of the next byte appears once this read ends; an empty slot carries no status
            if (st.rx_cnt != (AW+1)'(1)) begin
                next_st.pe = rx_mem[st.rx_rd + 1'b1].pe;
                next_st.fe = rx_mem[st.rx_rd + 1'b1].fe;
                next_st.brk = rx_mem[st.rx_rd + 1'b1].brk;
                next_st.rx_buffer_reg = rx_mem[st.rx_rd + 1'b1].data;
            end else begin
                next_st.pe = 1'b0;
                next_st.fe = 1'b0;
                next_st.brk = 1'b0;
            end
            next_st.cto_irq = 1'b0;
            next_st.cto_cnt = '0;
        end else if (rx_pop) begin
            next_st.data_ready = 1'b0;
        end
        if (rd_acc && idx == REG_LSR) begin
            next_st.overrun = 1'b0;
            next_st.pe = 1'b0;
            next_st.fe = 1'b0;
            next_st.brk = 1'b0;
        end
        if (rx_push) begin
            if (st.fifo_en && st.rx_cnt == (AW+1)'(DEPTH)) begin
                next_st.overrun = 1'b1;
            end else begin
                if (!st.fifo_en && st.data_ready) next_st.overrun = 1'b1;
                next_st.data_ready = 1'b1;
                if (st.fifo_en) begin
                    next_st.rx_wr = st.rx_wr + 1'b1;
                    next_st.rx_cnt = next_st.rx_cnt + 1'b1;
                end
                if (!st.fifo_en || st.rx_cnt == '0) begin
                    next_st.rx_buffer_reg = next_st.rx_pend.data;
                    next_st.pe = next_st.rx_pend.pe;
                    next_st.fe = next_st.rx_pend.fe;
                    next_st.brk = next_st.rx_pend.brk;
                end
            end
        end
        // Character timeout: no traffic for four characters, then eight samples
        if (!st.fifo_en || st.rx_cnt == '0 || st.rx_st != RX_IDLE || rx_push) begin
            next_st.cto_cnt = '0;
            next_st.cto_dly = '0;
        end else if (st.btick_q && !st.cto_irq) begin
            if (st.cto_cnt < 10'(CTO_CHARS * OVERSAMPLE * 10)) next_st.cto_cnt = st.cto_cnt + 10'd1;
            else if (st.cto_dly == 4'(RX_TIMEOUT_DELAY - 1)) next_st.cto_irq = 1'b1;
            else next_st.cto_dly = st.cto_dly + 4'd1;
        end
        // Modem deltas: hardware set wins over the clearing read
        if (rd_acc && idx == REG_MSR) next_st.m_delta = 4'h0;
        next_st.m_prev = st.modem_control_reg[4] ? {st.modem_control_reg[3], st.modem_control_reg[2], st.modem_control_reg[0], st.modem_control_reg[1]} : modem_in;
        next_st.m_delta = next_st.m_delta |
            {st.m_prev.dcd ^ next_st.m_prev.dcd, st.m_prev.ri & ~next_st.m_prev.ri,
             st.m_prev.dsr ^ next_st.m_prev.dsr, st.m_prev.cts ^ next_st.m_prev.cts};
        // Master clear; data buffers and divisor keep their contents
        if (reset) begin
            next_st = '0;
            next_st.divisor = st.divisor;
            next_st.tx_hold = st.tx_hold;
            next_st.rx_buffer_reg = st.rx_buffer_reg;
            next_st.tx_empty_irq = 1'b1;
            next_st.tx_line = 1'b1;
            next_st.m_prev = modem_in;
        end
    end

    always_ff @(posedge sys_clk) begin
        st <= next_st;
        prdata <= 32'h0;
        if (psel && !penable && !pwrite) prdata <= {24'h0, rd_byte};
        if (tx_push && st.fifo_en) tx_mem[st.tx_wr] <= pwdata[7:0];
        // The entry is built on the push tick itself, so store the fresh copy
        if (rx_push && st.fifo_en && st.rx_cnt != (AW+1)'(DEPTH)) rx_mem[st.rx_wr] <= next_st.rx_pend;
    end

    // Pin outputs: loop mode holds modem outputs inactive
    assign serial_out = st.modem_control_reg[4] ? 1'b1 : (st.tx_line & ~st.lcr[LCR_BREAK]);
    assign dtr_n = ~(st.modem_control_reg[0] & ~st.modem_control_reg[4]);
    assign rts_n = ~(st.modem_control_reg[1] & ~st.modem_control_reg[4]);
    assign out1_n = ~(st.modem_control_reg[2] & ~st.modem_control_reg[4]);
    assign out2_n = ~(st.modem_control_reg[3] & ~st.modem_control_reg[4]);
    assign baud_out_n = ~st.btick_q;
    assign tx_dma_request_n = st.tx_dma_blk;
    assign rx_dma_request_n = ~(st.data_ready & (!st.dma_mode || !st.fifo_en || 5'(st.rx_cnt) >= trig_lvl
                                || st.cto_irq));

    // Reset returns FIFO mode off
    a_reset_fifo_off: assert property (@(posedge sys_clk) reset |=> !st.fifo_en)
        else $error("fifo mode on after reset");
    a_thr_write_clear: assert property (@(posedge sys_clk) disable iff (reset)
        tx_push |=> !st.tx_empty_irq)
        else $error("holding write left empty interrupt");
    a_msr_read_clear: assert property (@(posedge sys_clk) disable iff (reset)
        (rd_acc && idx == REG_MSR && $stable(modem_in) && !st.modem_control_reg[4]) ##1 $stable(modem_in)
        |-> st.m_delta == 4'h0)
        else $error("modem delta not cleared");
    a_lsr_read_clear: assert property (@(posedge sys_clk) disable iff (reset)
        rd_acc && idx == REG_LSR && !rx_push |=> !st.overrun)
        else $error("overrun not cleared by status read");
    a_divisor_map: assert property (@(posedge sys_clk) disable iff (reset)
        wr_acc && idx == REG_DATA && divisor_access_bit |=> st.divisor[7:0] == $past(pwdata[7:0]))
        else $error("divisor low byte not written");
    // A read in the same cycle lowers the count though the byte is still dropped, so only a push into a full, unread FIFO is checked
    a_rx_overflow: assert property (@(posedge sys_clk) disable iff (reset)
        rx_push && !rx_pop && st.fifo_en && st.rx_cnt == (AW+1)'(DEPTH)
        |=> st.overrun && st.rx_cnt == (AW+1)'(DEPTH))
        else $error("overflow byte not discarded");
    a_fifo_depth: assert property (@(posedge sys_clk) disable iff (reset)
        st.rx_cnt <= (AW+1)'(DEPTH) && st.tx_cnt <= (AW+1)'(DEPTH))
        else $error("fifo count beyond depth");
    a_msi_set: assert property (@(posedge sys_clk) disable iff (reset)
        st.ier[IER_MS] && st.m_delta != 4'h0 |-> interrupt_output)
        else $error("modem interrupt not raised");
endmodule

// >>> tb/fuc_line_model.sv
// Serial line partner: drives frames into the receiver and captures transmitted frames
`timescale 1ns/100ps
module fuc_line_model (
    input wire logic sys_clk,
    input wire logic tx_line,
    output logic rx_line
);
    logic [7:0] got = 8'h00;
    int n_got = 0;
    initial rx_line = 1'b1;
    // One 8N1 frame, 16 clocks a bit at divisor one; line idles high
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line <= f[i];
            repeat (16) @(posedge sys_clk);
        end
    endtask
    // Sample each transmitted data bit mid-cell, least significant first
    always begin
        @(negedge tx_line);
        repeat (8) @(posedge sys_clk);
        repeat (8) begin
            repeat (16) @(posedge sys_clk);
            got = {tx_line, got[7:1]};
        end
        repeat (16) @(posedge sys_clk);
        n_got++;
    end
endmodule

// >>> tb/tb_top.sv
// Register-level testbench for the FIFO UART core
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    import fuc_pkg::*;
    logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sin;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic pready, sout, irq, dtr_n;
    fuc_modem_s modem_in = '0;
    logic [7:0] q;
    int mismatches = 0, n_checks = 0;
    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;
    fuc_uart DUT (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .serial_in(sin),
        .serial_out(sout), .modem_in(modem_in), .dtr_n(dtr_n), .rts_n(), .out1_n(), .out2_n(),
        .baud_out_n(), .interrupt_output(irq), .tx_dma_request_n(), .rx_dma_request_n());
    fuc_line_model LM (.sys_clk(sys_clk), .tx_line(sout), .rx_line(sin));
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // APB transfer: setup, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [2:0] r, input logic [7:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {27'h0, r, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge sys_clk); k++; end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin mismatches++; stop_test(); end
        q = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Main sequence
    initial begin
        int k;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        apb(0, REG_LCR, 8'h0); `CHK(q, 8'h00)
        apb(0, REG_IIR_FCR, 8'h0); `CHK(q[3:0], IID_NONE)
        `CHK({dtr_n, sout}, 2'b11)
        $display("reset test done");
        apb(1, REG_LCR, 8'h83); apb(1, REG_DATA, 8'h01); apb(1, REG_IER, 8'h00);
        apb(0, REG_DATA, 8'h0); `CHK(q, 8'h01)
        apb(1, REG_LCR, 8'h03);
        apb(1, REG_IER, 8'h02); @(posedge sys_clk); `CHK(irq, 1'b1)
        apb(0, REG_IIR_FCR, 8'h0); `CHK(q[3:0], IID_TX_HOLDING_EMPTY_IRQ)
        @(posedge sys_clk); `CHK(irq, 1'b0)
        apb(1, REG_IER, 8'h08); modem_in.cts <= 1'b1; repeat (4) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        apb(0, REG_MSR, 8'h0); `CHK({q[4], q[0]}, 2'b11)
        @(posedge sys_clk); `CHK(irq, 1'b0)
        apb(1, REG_IER, 8'h00);
        $display("interrupt test done");
        apb(1, REG_DATA, 8'ha5);
        k = 0;
        while (LM.n_got < 1 && k < 600) begin @(posedge sys_clk); k++; end
        if (k >= 600) begin mismatches++; stop_test(); end
        `CHK(LM.got, 8'ha5)
        LM.send(8'h3c);
        k = 0;
        do begin apb(0, REG_LSR, 8'h0); k++; end while (q[0] !== 1'b1 && k < 20);
        if (q[0] !== 1'b1) begin mismatches++; stop_test(); end
        apb(0, REG_DATA, 8'h0); `CHK(q, 8'h3c)
        apb(0, REG_LSR, 8'h0); `CHK(q[0], 1'b0)
        $display("serial test done");
        // FIFO mode: two frames come back in arrival order, status clean once drained
        apb(1, REG_IIR_FCR, 8'h01);
        apb(0, REG_IIR_FCR, 8'h0); `CHK(q[7:6], 2'b11)
        LM.send(8'h11);
        LM.send(8'h22);
        apb(0, REG_DATA, 8'h0); `CHK(q, 8'h11)
        apb(0, REG_DATA, 8'h0); `CHK(q, 8'h22)
        apb(0, REG_LSR, 8'h0); `CHK(q, 8'h60)
        $display("fifo test done");
        stop_test();
    end
endmodule
